// >>> shared/ncs_regs.svh
// Register map, field positions, command codes and reset values of the NVM command unit
`ifndef NCS_REGS_SVH
`define NCS_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define NCS_ADDR_STATUS   12'h000
`define NCS_ADDR_CMD      12'h004
`define NCS_ADDR_CLKDIV   12'h008
`define NCS_ADDR_ADDR     12'h00c
`define NCS_ADDR_PROT     12'h010
`define NCS_ADDR_IRQ_STS  12'h014
`define NCS_ADDR_IRQ_MSK  12'h018
`define NCS_ADDR_CTRL     12'h01c

// ----------------------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------------------
`define NCS_BIT_CBEF      7
`define NCS_BIT_CCF       6
`define NCS_BIT_PVIOL     5
`define NCS_BIT_ACCERR    4
`define NCS_BIT_BLANK     2

// ----------------------------------------------------------------------------
// Interrupt status bit positions
// ----------------------------------------------------------------------------
`define NCS_IRQ_DONE      0
`define NCS_IRQ_PVIOL     1
`define NCS_IRQ_ACCERR    2
`define NCS_IRQ_W         3

// Control register: bit 0 is the stop-mode request
`define NCS_BIT_STOP      0

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define NCS_CMD_BLANK     8'h05
`define NCS_CMD_BYTE      8'h20
`define NCS_CMD_BURST     8'h25
`define NCS_CMD_SECT      8'h40
`define NCS_CMD_MASS      8'h41
`define NCS_CMD_ABORT     8'h47

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define NCS_RST_PROT      16'hffff
`define NCS_RST_BYTE      8'h00
`define NCS_RST_ADDR      16'h0000
`define NCS_RST_IRQ       3'h0

`endif

// >>> shared/ncs_pkg.sv
// Types shared by the NVM command unit and its array sequencer
package ncs_pkg;

    // A command handed to the array sequencer
    typedef struct packed {
        logic [7:0]  code;
        logic [15:0] addr;
    } ncs_job_t;

    // AHB-Lite address phase captured for the data phase
    typedef struct packed {
        logic        write;
        logic [11:0] addr;
    } ncs_aphase_t;

endpackage : ncs_pkg

// >>> src/ncs_array_seq.sv
// Array sequencer: runs one command for a programmable number of cycles
`timescale 1ns/10ps
`default_nettype none
`include "ncs_regs.svh"
module ncs_array_seq #(
    parameter int OP_CYCLES = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire ncs_pkg::ncs_job_t job,
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic             array_erased,
    output logic                  busy,
    output logic                  done,
    output logic                  blank_ok
);
    // Elaboration check: one cycle would end a run before busy is seen,
    // and the run counter is only 16 bits wide
    if (OP_CYCLES < 2 || OP_CYCLES > 65536) begin : g_bad_cycles
        $error("OP_CYCLES must lie between 2 and 65536");
    end

    logic [15:0] cnt_q;
    logic        is_blank_q;

    // ------------------------------------------------------------------------
    // Busy counter; an abort ends the run at once
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cnt_q      <= 16'h0000;
            busy       <= 1'b0;
            done       <= 1'b0;
            is_blank_q <= 1'b0;
            blank_ok   <= 1'b0;
        end else begin
            done     <= 1'b0;
            blank_ok <= 1'b0;
            if (start && !busy) begin
                busy       <= 1'b1;
                cnt_q      <= 16'(OP_CYCLES - 1);
                is_blank_q <= (job.code == `NCS_CMD_BLANK);
            end else if (busy && (abort || cnt_q == 16'h0000)) begin
                busy     <= 1'b0;
                done     <= 1'b1;
                blank_ok <= is_blank_q && array_erased && !abort;
            end else if (busy) begin
                cnt_q <= cnt_q - 16'h0001;
            end
        end
    end
endmodule : ncs_array_seq
`default_nettype wire

// >>> src/ncs_cmd_unit.sv
// NVM command launch and status unit with AHB-Lite register slave
//
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ncs_regs.svh"

module ncs_cmd_unit #(
    parameter int OP_CYCLES = 16,
    parameter int SECT_BITS = 12
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic        array_erased,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    output logic             array_busy
);
    // Elaboration check on the sector size
    if (SECT_BITS < 1 || SECT_BITS > 15) begin : g_bad_sect
        $error("SECT_BITS out of range");
    end

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    ncs_pkg::ncs_aphase_t ap_q;
    logic                 ap_valid_q;
    logic                 cbef_q, ccf_q, pviol_q, accerr_q, blank_q;
    logic [7:0]           cmd_q;
    logic [7:0]           div_q;
    logic                 div_written_q;
    logic [15:0]          addr_q;
    logic [15:0]          prot_q;
    logic [`NCS_IRQ_W-1:0] irq_sts_q, irq_msk_q;
    logic                 stop_q;
    logic                 pend_q;
    ncs_pkg::ncs_job_t    pend_job_q;
    logic                 seq_busy, seq_done, seq_blank;
    logic                 seq_start;
    ncs_pkg::ncs_job_t    seq_job;

    // Decoded write strobes in the data phase
    logic wr_en;
    logic wr_status, wr_cmd, wr_div, wr_addr, wr_prot, wr_ists, wr_imsk, wr_ctrl;
    logic launch, legal, prog_like, protected_hit, seq_err;
    logic set_pviol, set_accerr, stop_err, job_go;
    logic [7:0] wb;

    assign wb        = hwdata[7:0];
    assign wr_en     = ap_valid_q && ap_q.write;
    assign wr_status = wr_en && ap_q.addr == `NCS_ADDR_STATUS;
    assign wr_cmd    = wr_en && ap_q.addr == `NCS_ADDR_CMD;
    assign wr_div    = wr_en && ap_q.addr == `NCS_ADDR_CLKDIV;
    assign wr_addr   = wr_en && ap_q.addr == `NCS_ADDR_ADDR;
    assign wr_prot   = wr_en && ap_q.addr == `NCS_ADDR_PROT;
    assign wr_ists   = wr_en && ap_q.addr == `NCS_ADDR_IRQ_STS;
    assign wr_imsk   = wr_en && ap_q.addr == `NCS_ADDR_IRQ_MSK;
    assign wr_ctrl   = wr_en && ap_q.addr == `NCS_ADDR_CTRL;

    // ------------------------------------------------------------------------
    // Command checks at launch time
    // ------------------------------------------------------------------------
    assign launch    = wr_status && wb[`NCS_BIT_CBEF] && cbef_q;
    // Six codes only; everything else is illegal
    assign legal     = cmd_q == `NCS_CMD_BLANK || cmd_q == `NCS_CMD_BYTE ||
                       cmd_q == `NCS_CMD_BURST ||
                       cmd_q == `NCS_CMD_SECT || cmd_q == `NCS_CMD_MASS ||
                       cmd_q == `NCS_CMD_ABORT;
    assign prog_like = cmd_q == `NCS_CMD_BYTE || cmd_q == `NCS_CMD_BURST ||
                       cmd_q == `NCS_CMD_SECT || cmd_q == `NCS_CMD_MASS;
    // Protected region is addr_q at or above the protection boundary;
    // the reset boundary protects nothing, not even the top address
    assign protected_hit = ((cmd_q == `NCS_CMD_MASS) && (prot_q != `NCS_RST_PROT))
                        || (prog_like && cmd_q != `NCS_CMD_MASS
                            && prot_q != `NCS_RST_PROT
                            && addr_q >= prot_q);
    // Only burst program may be queued while another command runs
    assign seq_err   = seq_busy && !(cmd_q == `NCS_CMD_BURST) &&
                       !(cmd_q == `NCS_CMD_ABORT);
    assign stop_err  = wr_ctrl && wb[`NCS_BIT_STOP] && !ccf_q;
    assign set_accerr = (launch && (!legal || seq_err ||
                        (prog_like && !div_written_q))) || stop_err;
    assign set_pviol = launch && !set_accerr && protected_hit;
    assign job_go    = launch && !set_accerr && !set_pviol &&
                       !(cmd_q == `NCS_CMD_ABORT);

    // Sequencer is fed from the queue or directly from a fresh launch
    assign seq_start = !seq_busy && (pend_q || job_go);
    assign seq_job   = pend_q ? pend_job_q : ncs_pkg::ncs_job_t'{code: cmd_q, addr: addr_q};

    ncs_array_seq #(
        .OP_CYCLES (OP_CYCLES)
    ) u_seq (
        .sys_clk      (sys_clk),
        .resetn       (resetn),
        .job          (seq_job),
        .start        (seq_start),
        .abort        (launch && legal && cmd_q == `NCS_CMD_ABORT && seq_busy),
        .array_erased (array_erased),
        .busy         (seq_busy),
        .done         (seq_done),
        .blank_ok     (seq_blank)
    );

    // ------------------------------------------------------------------------
    // AHB-Lite address phase capture; always zero wait, OKAY
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ap_valid_q <= 1'b0;
            ap_q       <= '0;
        end else if (hready) begin
            ap_valid_q <= hsel && htrans[1];
            ap_q       <= '{write: hwrite, addr: {haddr[11:2], 2'b00}};
        end
    end

    // ------------------------------------------------------------------------
    // Buffer-empty, queue and complete flags
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cbef_q     <= 1'b1;
            ccf_q      <= 1'b1;
            pend_q     <= 1'b0;
            pend_job_q <= '0;
        end else begin
            if (job_go && seq_busy) begin
                pend_q     <= 1'b1;
                pend_job_q <= '{code: cmd_q, addr: addr_q};
                cbef_q     <= 1'b0;
            end else if (pend_q && !seq_busy) begin
                pend_q <= 1'b0;
                cbef_q <= 1'b1;
            end else if (launch) begin
                // Short hold while a direct launch enters the sequencer
                cbef_q <= !job_go;
            end else if (!pend_q) begin
                cbef_q <= 1'b1;
            end
            // Complete only when nothing runs and nothing is queued
            if (job_go) begin
                ccf_q <= 1'b0;
            end else begin
                ccf_q <= !seq_busy && !pend_q && !seq_start;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Error and blank flags; a set beats a same-cycle clear
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pviol_q  <= 1'b0;
            accerr_q <= 1'b0;
            blank_q  <= 1'b0;
        end else begin
            if (set_pviol) begin
                pviol_q <= 1'b1;
            end else if (wr_status && wb[`NCS_BIT_PVIOL]) begin
                pviol_q <= 1'b0;
            end
            if (set_accerr) begin
                accerr_q <= 1'b1;
            end else if (wr_status && wb[`NCS_BIT_ACCERR]) begin
                accerr_q <= 1'b0;
            end
            if (seq_blank) begin
                blank_q <= 1'b1;
            end else if (job_go) begin
                blank_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Software registers; divider write is remembered until reset
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cmd_q         <= `NCS_RST_BYTE;
            div_q         <= `NCS_RST_BYTE;
            div_written_q <= 1'b0;
            addr_q        <= `NCS_RST_ADDR;
            prot_q        <= `NCS_RST_PROT;
            irq_msk_q     <= `NCS_RST_IRQ;
            stop_q        <= 1'b0;
        end else begin
            // Command and address are frozen while the buffer is full
            if (wr_cmd && cbef_q) cmd_q <= wb;
            if (wr_addr && cbef_q) addr_q <= hwdata[15:0];
            if (wr_div) begin
                div_q         <= wb;
                div_written_q <= 1'b1;
            end
            // Protection may only grow: lower boundary means more protected
            if (wr_prot && hwdata[15:0] < prot_q) prot_q <= hwdata[15:0];
            if (wr_imsk) irq_msk_q <= hwdata[`NCS_IRQ_W-1:0];
            if (wr_ctrl) stop_q <= wb[`NCS_BIT_STOP];
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt status, write one to clear, set wins
    // ------------------------------------------------------------------------
    // Event sources, one per interrupt status bit
    logic [`NCS_IRQ_W-1:0] irq_ev;
    assign irq_ev[`NCS_IRQ_DONE]   = seq_done;
    assign irq_ev[`NCS_IRQ_PVIOL]  = set_pviol;
    assign irq_ev[`NCS_IRQ_ACCERR] = set_accerr;

    // One sticky bit per event; an event in the clearing cycle is kept,
    // so software never loses an event it has not yet seen
    for (genvar gi = 0; gi < `NCS_IRQ_W; gi++) begin : g_irq_sts
        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                irq_sts_q[gi] <= 1'b0;
            end else if (irq_ev[gi]) begin
                irq_sts_q[gi] <= 1'b1;
            end else if (wr_ists && hwdata[gi]) begin
                irq_sts_q[gi] <= 1'b0;
            end
        end
    end

    // Level output one cycle behind the status, so it comes from a flop
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_sts_q & irq_msk_q);
        end
    end

    // ------------------------------------------------------------------------
    // Read data; registered so outputs come from flops
    // ------------------------------------------------------------------------
    logic [31:0] rd_d;
    always_comb begin
        rd_d = 32'h0000_0000;
        case (haddr[11:2])
            10'(`NCS_ADDR_STATUS >> 2): begin
                rd_d[`NCS_BIT_CBEF]   = cbef_q;
                rd_d[`NCS_BIT_CCF]    = ccf_q;
                rd_d[`NCS_BIT_PVIOL]  = pviol_q;
                rd_d[`NCS_BIT_ACCERR] = accerr_q;
                rd_d[`NCS_BIT_BLANK]  = blank_q;
            end
            10'(`NCS_ADDR_CMD >> 2):     rd_d[7:0] = cmd_q;
            10'(`NCS_ADDR_CLKDIV >> 2):  rd_d[7:0] = div_q;
            10'(`NCS_ADDR_ADDR >> 2):    rd_d[15:0] = addr_q;
            10'(`NCS_ADDR_PROT >> 2):    rd_d[15:0] = prot_q;
            10'(`NCS_ADDR_IRQ_STS >> 2): rd_d[`NCS_IRQ_W-1:0] = irq_sts_q;
            10'(`NCS_ADDR_IRQ_MSK >> 2): rd_d[`NCS_IRQ_W-1:0] = irq_msk_q;
            10'(`NCS_ADDR_CTRL >> 2):    rd_d[0] = stop_q;
            default:                rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            hrdata     <= 32'h0000_0000;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            array_busy <= 1'b0;
        end else begin
            if (hready && hsel && htrans[1] && !hwrite) hrdata <= rd_d;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            array_busy <= seq_busy;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    AST_LAUNCH_CLR_CCF: assert property (@(posedge sys_clk) disable iff (!resetn)
        job_go |=> !ccf_q) else $error("complete flag not cleared on launch");
    AST_PVIOL_SET: assert property (@(posedge sys_clk) disable iff (!resetn)
        set_pviol |=> pviol_q && !$rose(seq_busy)) else $error("violation not flagged");
    AST_PVIOL_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
        $fell(pviol_q) |-> $past(wr_status && wb[`NCS_BIT_PVIOL]))
        else $error("violation flag cleared without write one");
    AST_ACCERR_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
        $fell(accerr_q) |-> $past(wr_status && wb[`NCS_BIT_ACCERR]))
        else $error("access error cleared without write one");
    AST_ILLEGAL: assert property (@(posedge sys_clk) disable iff (!resetn)
        launch && !legal |=> accerr_q && !$rose(seq_busy)) else $error("illegal code accepted");
    AST_NODIV: assert property (@(posedge sys_clk) disable iff (!resetn)
        launch && prog_like && !div_written_q |=> accerr_q) else $error("no divider error");
    AST_STOP: assert property (@(posedge sys_clk) disable iff (!resetn)
        stop_err |=> accerr_q) else $error("stop error missed");
    AST_MASS_PROT: assert property (@(posedge sys_clk) disable iff (!resetn)
        launch && legal && cmd_q == `NCS_CMD_MASS && prot_q != `NCS_RST_PROT
        && div_written_q && !seq_err |=> pviol_q) else $error("mass erase not refused");
    AST_BLANK: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(blank_q) |-> $past(seq_done)) else $error("blank flag outside completion");
    // Watches the bus output itself, one edge after the status read is taken
    AST_STATUS_ZERO: assert property (@(posedge sys_clk) disable iff (!resetn)
        hready && hsel && htrans[1] && !hwrite
        && haddr[11:2] == 10'(`NCS_ADDR_STATUS >> 2)
        |=> hrdata[3] == 1'b0 && hrdata[1:0] == 2'b00)
        else $error("undefined status bit reads one");
    AST_CBEF_CLR: assert property (@(posedge sys_clk) disable iff (!resetn)
        job_go |=> !cbef_q) else $error("buffer flag not cleared on launch");
    AST_QUEUE_BURST: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(pend_q) |-> $past(cmd_q == `NCS_CMD_BURST))
        else $error("non-burst command queued");
    AST_SEQ_ERR: assert property (@(posedge sys_clk) disable iff (!resetn)
        launch && seq_err |=> accerr_q) else $error("sequence error not flagged");
    AST_BLANK_CLR: assert property (@(posedge sys_clk) disable iff (!resetn)
        job_go && !seq_blank |=> !blank_q) else $error("blank flag kept on launch");
    AST_LEGAL_START: assert property (@(posedge sys_clk) disable iff (!resetn)
        seq_start && !pend_q |-> legal) else $error("illegal code started");
    AST_ABORT: assert property (@(posedge sys_clk) disable iff (!resetn)
        launch && legal && cmd_q == `NCS_CMD_ABORT && seq_busy |=> !seq_busy)
        else $error("abort left the array running");
endmodule : ncs_cmd_unit
`default_nettype wire

// >>> dv/ncs_cmd_unit_bench.sv
// Self-checking bench for the NVM command launch and status unit
`timescale 1ns/10ps
`default_nettype none
`include "ncs_regs.svh"
module ncs_cmd_unit_bench;
    // ------------------------------------------------------------------------
    // Stimulus and observation signals
    // ------------------------------------------------------------------------
    logic        sys_clk      = 1'b0;
    logic        resetn       = 1'b0;
    logic        hsel         = 1'b0;
    logic [11:0] haddr        = 12'h000;
    logic [1:0]  htrans       = 2'h0;
    logic        hwrite       = 1'b0;
    logic [2:0]  hsize        = 3'h2;
    logic [31:0] hwdata       = 32'h0;
    logic        array_erased = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    logic        array_busy;
    logic [31:0] rd;
    logic [15:0] seed         = 16'h4c69;
    logic [7:0]  codes [6]    = '{8'h05, 8'h20, 8'h05, 8'h25, 8'h40, 8'h41};
    int          fail_count   = 0;
    int          n_tests      = 0;

    // Short array runs keep every command wait small
    ncs_cmd_unit #(.OP_CYCLES(8)) dut (
        .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .array_erased(array_erased), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .irq(irq), .array_busy(array_busy));

    always #2.5 sys_clk = ~sys_clk;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // Flags expected once a command has run its course
    function automatic logic [31:0] exp_sts(input logic [7:0] c, input logic dv, input logic er);
        if (!(c inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41, 8'h47})) return 32'hd0;
        if (!dv && !(c inside {8'h05, 8'h47})) return 32'hd0;
        return (c == 8'h05 && er) ? 32'hc4 : 32'hc0;
    endfunction : exp_sts

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One single transfer; the bench's own timeout guards each wait
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask : rdchk

    task automatic launch(input logic [7:0] c, input logic [15:0] a);
        bus(1'b1, `NCS_ADDR_ADDR, {16'h0, a});
        bus(1'b1, `NCS_ADDR_CMD, {24'h0, c});
        bus(1'b1, `NCS_ADDR_STATUS, 32'h80);
    endtask : launch

    // Polls until the complete flag is back; rd then holds the final status
    task automatic wait_idle();
        for (int i = 0; i < 40; i++) begin
            bus(1'b0, `NCS_ADDR_STATUS, 32'h0);
            if (rd[6] === 1'b1) break;
        end
        chk({31'h0, rd[6]}, 32'h1);
    endtask : wait_idle

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    // Watchdog: the whole sequence needs a few thousand cycles at most
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        end_sim();
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        logic [7:0] c;
        logic       er;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        rdchk(`NCS_ADDR_STATUS, 32'hff, 32'hc0);
        rdchk(12'h020, 32'hffffffff, 32'h0);
        chk({30'h0, hreadyout, hresp}, 32'h2);
        bus(1'b1, `NCS_ADDR_STATUS, 32'h4f);
        rdchk(`NCS_ADDR_STATUS, 32'hff, 32'hc0);
        // Program before the divider is set must be refused
        launch(8'h20, 16'h0100);
        rdchk(`NCS_ADDR_STATUS, 32'hf4, 32'hd0);
        bus(1'b1, `NCS_ADDR_STATUS, 32'h00);
        rdchk(`NCS_ADDR_STATUS, 32'hf4, 32'hd0);
        rdchk(`NCS_ADDR_IRQ_STS, 32'h4, 32'h4);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, `NCS_ADDR_IRQ_MSK, 32'h7);
        // The mask lands, then the flop behind irq follows one edge later
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, `NCS_ADDR_STATUS, 32'h10);
        bus(1'b1, `NCS_ADDR_IRQ_STS, 32'h7);
        rdchk(`NCS_ADDR_STATUS, 32'hff, 32'hc0);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, `NCS_ADDR_CLKDIV, 32'h13);
        // Five of the six legal codes by table (blank twice, no abort), then random illegal ones
        // Mass erase ends the table: no blank check is owed after it
        for (int i = 0; i < 14; i++) begin
            seed = lfsr(seed);
            c = (i < 6) ? codes[i] : seed[7:0];
            if (i >= 6 && c inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41, 8'h47}) c = c ^ 8'h80;
            er = (i == 0) ? 1'b1 : (i == 2) ? 1'b0 : seed[8];
            array_erased <= er;
            launch(c, {1'b0, seed[14:0]});
            if (i < 6) begin
                rdchk(`NCS_ADDR_STATUS, 32'h44, 32'h0);
                chk({31'h0, array_busy}, 32'h1);
            end
            wait_idle();
            chk(rd & 32'hf4, exp_sts(c, 1'b1, er));
            if (i == 0) chk({31'h0, irq}, 32'h1);
            bus(1'b1, `NCS_ADDR_STATUS, 32'h30);
            bus(1'b1, `NCS_ADDR_IRQ_STS, 32'h7);
        end
        // Protection boundary lowered; raising it again is refused
        bus(1'b1, `NCS_ADDR_PROT, 32'h8000);
        bus(1'b1, `NCS_ADDR_PROT, 32'hffff);
        rdchk(`NCS_ADDR_PROT, 32'hffff, 32'h8000);
        launch(8'h20, 16'h9000);
        rdchk(`NCS_ADDR_STATUS, 32'hf4, 32'he0);
        bus(1'b1, `NCS_ADDR_STATUS, 32'h00);
        rdchk(`NCS_ADDR_STATUS, 32'hf4, 32'he0);
        bus(1'b1, `NCS_ADDR_STATUS, 32'h20);
        launch(8'h41, 16'h0000);
        rdchk(`NCS_ADDR_STATUS, 32'hf4, 32'he0);
        bus(1'b1, `NCS_ADDR_STATUS, 32'h20);
        // A second burst queues behind a running one
        launch(8'h25, 16'h0010);
        bus(1'b1, `NCS_ADDR_CMD, 32'h25);
        bus(1'b1, `NCS_ADDR_STATUS, 32'h80);
        rdchk(`NCS_ADDR_STATUS, 32'hd0, 32'h00);
        wait_idle();
        chk(rd & 32'hf4, 32'hc0);
        // A byte program during a running erase breaks the sequence
        launch(8'h40, 16'h0200);
        bus(1'b1, `NCS_ADDR_CMD, 32'h20);
        bus(1'b1, `NCS_ADDR_STATUS, 32'h80);
        rdchk(`NCS_ADDR_STATUS, 32'h10, 32'h10);
        wait_idle();
        bus(1'b1, `NCS_ADDR_STATUS, 32'h30);
        // Abort of a running sector erase ends it cleanly
        launch(8'h40, 16'h0400);
        bus(1'b1, `NCS_ADDR_CMD, 32'h47);
        bus(1'b1, `NCS_ADDR_STATUS, 32'h80);
        wait_idle();
        chk(rd & 32'hf4, 32'hc0);
        // Stop request while a command runs
        launch(8'h20, 16'h0300);
        bus(1'b1, `NCS_ADDR_CTRL, 32'h1);
        rdchk(`NCS_ADDR_STATUS, 32'h10, 32'h10);
        bus(1'b1, `NCS_ADDR_CTRL, 32'h0);
        wait_idle();
        // Reset once idle: flags return to idle and the divider must be set again
        resetn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        rdchk(`NCS_ADDR_STATUS, 32'hff, 32'hc0);
        chk({30'h0, irq, array_busy}, 32'h0);
        launch(8'h40, 16'h0100);
        rdchk(`NCS_ADDR_STATUS, 32'hf4, 32'hd0);
        end_sim();
    end
endmodule : ncs_cmd_unit_bench
`default_nettype wire
